/* File: design/dacp_defs.svh */
`ifndef DACP_DEFS_SVH
`define DACP_DEFS_SVH

// ========================================
// Synchronised pin vector positions
`define DACP_PIN_ENC_POS 6
`define DACP_PIN_ENC_NEG 5
`define DACP_PIN_STRAP 4
`define DACP_PIN_CS_N 3
`define DACP_PIN_SCK 2
`define DACP_PIN_SDI 1
`define DACP_PIN_SDO 0
`define DACP_PIN_COUNT 7

// ========================================
// Serial frame layout and mode control register indices
`define DACP_FRAME_BITS 5'h10
`define DACP_FRAME_LAST 5'h0F
`define DACP_ADDR_DONE 5'h07
`define DACP_DATA_FIRST 5'h08
`define DACP_REG_DCS 2'h0
`define DACP_REG_FMT 2'h1
`define DACP_REG_PDN 2'h2
`define DACP_REG_PHASE 2'h3
`define DACP_REG_RESET 8'h00
`define DACP_PDN_AWAKE 2'h0

// ========================================
// Timing counts
`define DACP_STRAP_WAIT 2'h2

`endif

/* File: design/dacp_pkg.sv */
package dacp_pkg;
    typedef struct packed {
        logic [15:0] word;
        logic range_flag;
    } dacp_sample_t;

    typedef struct packed {
        logic dcs;
        logic [1:0] fmt;
        logic [1:0] pdn;
        logic [1:0] phase;
    } dacp_mode_t;
endpackage

/* File: design/dacp_top.sv */
`include "dacp_defs.svh"

module dacp_top
    import dacp_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic encode_clock_pos_in,
    input wire logic encode_clock_neg_in,
    input wire logic config_mode_strap_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_sdi_in,
    input wire logic spi_sdo_in,
    input wire logic [15:0] chan1_conv_in,
    input wire logic [15:0] chan2_conv_in,
    input wire logic chan1_ovr_in,
    input wire logic chan2_ovr_in,
    output logic [15:0] chan1_sample_bus_out,
    output logic [15:0] chan2_sample_bus_out,
    output logic chan1_range_flag_out,
    output logic chan2_range_flag_out,
    output logic fwd_data_clock_pos_out,
    output logic fwd_data_clock_neg_out,
    output logic conv_start_out,
    output logic dcs_enable_out,
    output logic [1:0] out_format_out,
    output logic [1:0] power_down_out,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_out
);

    // ========================================
    // Pin synchronisers
    logic [`DACP_PIN_COUNT-1:0] pin_raw;
    logic [`DACP_PIN_COUNT-1:0] pin_meta_q;
    logic [`DACP_PIN_COUNT-1:0] pin_sync_q;
    logic [`DACP_PIN_COUNT-1:0] pin_prev_q;

    assign pin_raw = {encode_clock_pos_in, encode_clock_neg_in, config_mode_strap_in,
                      spi_cs_n_in, spi_sck_in, spi_sdi_in, spi_sdo_in};

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end
        else
        begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    logic enc_lvl;
    logic enc_prev_q;
    logic enc_rise;
    logic cs_n;
    logic sck_rise;
    logic sck_fall;

    assign enc_lvl = pin_sync_q[`DACP_PIN_ENC_POS] & ~pin_sync_q[`DACP_PIN_ENC_NEG];
    assign enc_rise = enc_lvl & ~enc_prev_q;
    assign cs_n = pin_sync_q[`DACP_PIN_CS_N];
    assign sck_rise = pin_sync_q[`DACP_PIN_SCK] & ~pin_prev_q[`DACP_PIN_SCK];
    assign sck_fall = ~pin_sync_q[`DACP_PIN_SCK] & pin_prev_q[`DACP_PIN_SCK];

    // ========================================
    // Strap capture after reset release
    logic strap_q;
    logic strap_done_q;
    logic [1:0] strap_wait_q;
    logic ser_mode;
    logic par_mode;

    // Pin chain is cleared by reset, so let it refill before latching the strap
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            strap_q <= 1'b0;
            strap_done_q <= 1'b0;
            strap_wait_q <= '0;
        end
        else if (strap_wait_q != `DACP_STRAP_WAIT)
        begin
            strap_wait_q <= strap_wait_q + 2'h1;
        end
        else if (!strap_done_q)
        begin
            strap_q <= pin_sync_q[`DACP_PIN_STRAP];
            strap_done_q <= 1'b1;
        end
    end

    assign ser_mode = strap_done_q & ~strap_q;
    assign par_mode = strap_done_q & strap_q;

    // ========================================
    // Serial port shifter and mode control registers
    logic [14:0] shift_q;
    logic [4:0] bit_cnt_q;
    logic rd_q;
    logic [1:0] rd_addr_q;
    logic [7:0] mode_regs_q [4];
    logic wr_commit;
    logic [2:0] rd_bit;

    assign wr_commit = ser_mode & ~cs_n & sck_rise & (bit_cnt_q == `DACP_FRAME_LAST)
                       & ~shift_q[14];
    assign rd_bit = 3'(`DACP_FRAME_LAST - bit_cnt_q);

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            shift_q <= '0;
            bit_cnt_q <= '0;
            rd_q <= 1'b0;
            rd_addr_q <= '0;
        end
        else if (!ser_mode || cs_n)
        begin
            bit_cnt_q <= '0;
            rd_q <= 1'b0;
        end
        else if (sck_rise && bit_cnt_q != `DACP_FRAME_BITS)
        begin
            shift_q <= {shift_q[13:0], pin_sync_q[`DACP_PIN_SDI]};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `DACP_ADDR_DONE)
            begin
                rd_q <= shift_q[6];
                rd_addr_q <= {shift_q[0], pin_sync_q[`DACP_PIN_SDI]};
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < 4; i++)
            begin
                mode_regs_q[i] <= `DACP_REG_RESET;
            end
        end
        else if (wr_commit)
        begin
            mode_regs_q[shift_q[8:7]] <= {shift_q[6:0], pin_sync_q[`DACP_PIN_SDI]};
        end
    end

    // Open-drain readback: enable pulls low for a zero bit
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            spi_sdo_oe_out <= 1'b0;
        end
        else if (!ser_mode || cs_n || !rd_q)
        begin
            spi_sdo_oe_out <= 1'b0;
        end
        else if (sck_fall)
        begin
            if (bit_cnt_q >= `DACP_DATA_FIRST && bit_cnt_q <= `DACP_FRAME_LAST)
            begin
                spi_sdo_oe_out <= ~mode_regs_q[rd_addr_q][rd_bit];
            end
            else
            begin
                spi_sdo_oe_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            spi_sdo_out <= 1'b0;
        end
        else
        begin
            spi_sdo_out <= 1'b0;
        end
    end

    // ========================================
    // Effective operating modes
    dacp_mode_t mode_eff;

    always_comb
    begin
        mode_eff.phase = mode_regs_q[`DACP_REG_PHASE][1:0];
        if (par_mode)
        begin
            mode_eff.dcs = pin_sync_q[`DACP_PIN_CS_N];
            mode_eff.fmt = {1'b0, pin_sync_q[`DACP_PIN_SCK]};
            mode_eff.pdn = {pin_sync_q[`DACP_PIN_SDI], pin_sync_q[`DACP_PIN_SDO]};
        end
        else
        begin
            mode_eff.dcs = mode_regs_q[`DACP_REG_DCS][0];
            mode_eff.fmt = mode_regs_q[`DACP_REG_FMT][1:0];
            mode_eff.pdn = mode_regs_q[`DACP_REG_PDN][1:0];
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            dcs_enable_out <= 1'b0;
            out_format_out <= '0;
            power_down_out <= '0;
        end
        else
        begin
            dcs_enable_out <= mode_eff.dcs;
            out_format_out <= mode_eff.fmt;
            power_down_out <= mode_eff.pdn;
        end
    end

    // ========================================
    // Conversion start and sample port
    logic awake;
    dacp_sample_t ch1_s;
    dacp_sample_t ch2_s;

    assign awake = (mode_eff.pdn == `DACP_PDN_AWAKE);
    assign ch1_s = '{word: chan1_conv_in, range_flag: chan1_ovr_in};
    assign ch2_s = '{word: chan2_conv_in, range_flag: chan2_ovr_in};

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            enc_prev_q <= 1'b0;
            conv_start_out <= 1'b0;
            chan1_sample_bus_out <= '0;
            chan2_sample_bus_out <= '0;
            chan1_range_flag_out <= 1'b0;
            chan2_range_flag_out <= 1'b0;
        end
        else
        begin
            enc_prev_q <= enc_lvl;
            conv_start_out <= enc_rise & awake;
            if (enc_rise && awake)
            begin
                chan1_sample_bus_out <= ch1_s.word;
                chan2_sample_bus_out <= ch2_s.word;
                chan1_range_flag_out <= ch1_s.range_flag;
                chan2_range_flag_out <= ch2_s.range_flag;
            end
        end
    end

    // ========================================
    // Forwarded data clock with phase delay taps
    logic [3:0] fwd_tap_q;
    logic [3:0] fwd_taps;

    assign fwd_taps = {fwd_tap_q[2:0], ~enc_lvl};

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            fwd_tap_q <= 4'hF;
            fwd_data_clock_pos_out <= 1'b1;
            fwd_data_clock_neg_out <= 1'b0;
        end
        else
        begin
            fwd_tap_q <= fwd_taps;
            fwd_data_clock_pos_out <= fwd_taps[mode_eff.phase];
            fwd_data_clock_neg_out <= ~fwd_taps[mode_eff.phase];
        end
    end

    // ========================================
    // Checks
    property p_conv_start;
        @(posedge clock_in) disable iff (sys_rst_in)
        (enc_rise && awake) |=> conv_start_out ##1 !conv_start_out;
    endproperty
    a_conv_start: assert property (p_conv_start) else $error("conversion start missing");

    property p_sample_word;
        @(posedge clock_in) disable iff (sys_rst_in)
        (enc_rise && awake) |=> chan1_sample_bus_out == $past(chan1_conv_in)
            && chan2_sample_bus_out == $past(chan2_conv_in);
    endproperty
    a_sample_word: assert property (p_sample_word) else $error("sample not latched");

    property p_range_flag;
        @(posedge clock_in) disable iff (sys_rst_in)
        (enc_rise && awake) |=> chan1_range_flag_out == $past(chan1_ovr_in)
            && chan2_range_flag_out == $past(chan2_ovr_in);
    endproperty
    a_range_flag: assert property (p_range_flag) else $error("range flag wrong");

    property p_fwd_comp;
        @(posedge clock_in) disable iff (sys_rst_in)
        fwd_data_clock_neg_out == !fwd_data_clock_pos_out;
    endproperty
    a_fwd_comp: assert property (p_fwd_comp) else $error("clock pair not complementary");

    property p_fwd_fall;
        @(posedge clock_in) disable iff (sys_rst_in)
        (enc_rise && mode_eff.phase == 2'h0 && $stable(mode_eff.phase))
            |=> $fell(fwd_data_clock_pos_out);
    endproperty
    a_fwd_fall: assert property (p_fwd_fall) else $error("forwarded clock not falling");

    property p_fwd_delay;
        @(posedge clock_in) disable iff (sys_rst_in)
        (enc_rise && mode_eff.phase == 2'h2) ##1 (mode_eff.phase == 2'h2)[*2]
            |=> !fwd_data_clock_pos_out;
    endproperty
    a_fwd_delay: assert property (p_fwd_delay) else $error("phase delay wrong");

    property p_sdo_low;
        @(posedge clock_in) disable iff (sys_rst_in)
        !spi_sdo_out && (!par_mode || !spi_sdo_oe_out);
    endproperty
    a_sdo_low: assert property (p_sdo_low) else $error("sdo driven high");

    property p_cs_idle;
        @(posedge clock_in) disable iff (sys_rst_in)
        (ser_mode && cs_n) |=> bit_cnt_q == 5'h00 && !wr_commit;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("shift outside chip select");

    property p_write;
        @(posedge clock_in) disable iff (sys_rst_in)
        wr_commit |=> mode_regs_q[$past(shift_q[8:7])]
            == {$past(shift_q[6:0]), $past(pin_sync_q[`DACP_PIN_SDI])};
    endproperty
    a_write: assert property (p_write) else $error("write not stored");

    property p_par_modes;
        @(posedge clock_in) disable iff (sys_rst_in)
        par_mode |=> dcs_enable_out == $past(pin_sync_q[`DACP_PIN_CS_N])
            && out_format_out[0] == $past(pin_sync_q[`DACP_PIN_SCK])
            && power_down_out == $past({pin_sync_q[`DACP_PIN_SDI], pin_sync_q[`DACP_PIN_SDO]});
    endproperty
    a_par_modes: assert property (p_par_modes) else $error("parallel mode pins ignored");

endmodule

/* File: tb/dacp_spi_host.sv */
// ========================================
// SPI host and static pin driver
module dacp_spi_host (
    input wire logic clock_in,
    input wire logic sdo_pin_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // Static levels for parallel mode
    task automatic set_pins(input logic cs, input logic ck, input logic di);
        @(posedge clock_in);
        cs_n_out <= cs;
        sck_out <= ck;
        sdi_out <= di;
    endtask

    // Sixteen bits MSB first; sel low clocks the frame with chip select high
    task automatic xfer(input logic sel, input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clock_in);
        cs_n_out <= ~sel;
        wait_cyc(4);
        for (int i = 15; i >= 0; i--)
        begin
            sdi_out <= frame[i];
            wait_cyc(4);
            sck_out <= 1'b1;
            wait_cyc(4);
            sck_out <= 1'b0;
            if (i < 8)
            begin
                rd[i] = sdo_pin_in;
            end
        end
        wait_cyc(4);
        cs_n_out <= 1'b1;
        wait_cyc(4);
    endtask
endmodule

/* File: tb/tb_dual_adc_config_and_output_port.sv */
// ========================================
// Bench for the converter control block
module tb_dual_adc_config_and_output_port;
    timeunit 1ns;
    timeprecision 1ns;
    import dacp_pkg::*;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic enc = 1'b0;
    logic strap = 1'b0;
    logic par_sdo = 1'b0;
    logic [15:0] c1 = 16'hFFFF;
    logic [15:0] c2 = 16'h8000;
    logic o1 = 1'b1;
    logic o2 = 1'b0;
    logic [1:0] phase_exp = 2'h0;
    logic [7:0] d [4];
    logic [7:0] v;
    logic mon_on = 1'b0;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 26;
    int cycles = 0;
    int conv_count = 0;
    int cnt = 0;
    int k = 99;
    wire logic [15:0] s1, s2;
    wire logic [1:0] fmt, pdn;
    wire logic f1, f2, fp, fn, cst, dcs, sdo_o, sdo_oe, cs_n, sck, sdi, sdo_pin;

    // Pull-up on SDO in serial mode
    assign sdo_pin = strap ? par_sdo : (sdo_oe ? sdo_o : 1'b1);

    always #25 clock_in = ~clock_in;

    initial
    begin
        #13;
        forever #200 enc = ~enc;
    end

    dacp_top DUT (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .encode_clock_pos_in(enc),
        .encode_clock_neg_in(~enc),
        .config_mode_strap_in(strap),
        .spi_cs_n_in(cs_n),
        .spi_sck_in(sck),
        .spi_sdi_in(sdi),
        .spi_sdo_in(sdo_pin),
        .chan1_conv_in(c1),
        .chan2_conv_in(c2),
        .chan1_ovr_in(o1),
        .chan2_ovr_in(o2),
        .chan1_sample_bus_out(s1),
        .chan2_sample_bus_out(s2),
        .chan1_range_flag_out(f1),
        .chan2_range_flag_out(f2),
        .fwd_data_clock_pos_out(fp),
        .fwd_data_clock_neg_out(fn),
        .conv_start_out(cst),
        .dcs_enable_out(dcs),
        .out_format_out(fmt),
        .power_down_out(pdn),
        .spi_sdo_out(sdo_o),
        .spi_sdo_oe_out(sdo_oe)
    );

    dacp_spi_host host (
        .clock_in(clock_in),
        .sdo_pin_in(sdo_pin),
        .cs_n_out(cs_n),
        .sck_out(sck),
        .sdi_out(sdi)
    );

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] msk(input logic [1:0] r);
        return (r == 2'h0) ? 8'h01 : 8'h03;
    endfunction

    task automatic wr(input logic [1:0] r, input logic [7:0] val);
        logic [7:0] unused;
        host.xfer(1'b1, {6'h00, r, val}, unused);
    endtask

    task automatic rd_chk(input logic [1:0] r, input logic [7:0] exp);
        logic [7:0] got;
        host.xfer(1'b1, {6'h20, r, 8'h00}, got);
        check("readback", {8'h00, got & msk(r)}, {8'h00, exp & msk(r)});
    endtask

    // Sample port monitor and hang guard
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            fail_count++;
            end_sim();
        end
        else if (mon_on)
        begin
            check("fwd_neg", {15'h0000, fn}, {15'h0000, ~fp});
            if (sdo_oe === 1'b1)
                check("sdo_drive", {15'h0000, sdo_o}, 16'h0000);
            k = (cst === 1'b1) ? 0 : k + 1;
            if (k <= phase_exp)
                check("fwd_pos", {15'h0000, fp}, {15'h0000, k < phase_exp});
            if (cst === 1'b1)
            begin
                conv_count++;
                check("chan1", s1, c1);
                check("chan2", s2, c2);
                check("flags", {14'h0000, f1, f2}, {14'h0000, o1, o2});
                c1 <= 16'($random(seed));
                c2 <= 16'($random(seed));
                o1 <= 1'($random(seed));
                o2 <= 1'($random(seed));
            end
        end
    end

    initial
    begin
        repeat (16) @(posedge clock_in);
        check("reset_out", {12'h000, fp, fn, sdo_oe, cst}, 16'h0008);
        sys_rst_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        mon_on <= 1'b1;
        for (int r = 0; r < 4; r++)
        begin
            d[r] = 8'($random(seed)) | ((r == 2) ? 8'h01 : 8'h00);
            wr(2'(r), d[r]);
        end
        phase_exp <= d[3][1:0];
        for (int r = 0; r < 4; r++)
            rd_chk(2'(r), d[r]);
        check("modes", {11'h000, dcs, fmt, pdn}, {11'h000, d[0][0], d[1][1:0], d[2][1:0]});
        cnt = conv_count;
        repeat (40) @(posedge clock_in);
        check("conv_stop", 16'(conv_count), 16'(cnt));
        host.xfer(1'b0, {8'h01, ~d[1]}, v);
        rd_chk(2'h1, d[1]);
        for (int p = 0; p < 4; p++)
        begin
            wr(2'h2, 8'h01);
            wr(2'h3, 8'(p));
            phase_exp <= 2'(p);
            wr(2'h2, 8'h00);
            cnt = conv_count;
            repeat (40) @(posedge clock_in);
            check("conv_run", 16'(conv_count > cnt + 3), 16'h0001);
        end
        $display("test serial done");
        sys_rst_in <= 1'b1;
        strap <= 1'b1;
        phase_exp <= 2'h0;
        repeat (8) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            host.set_pins(i[3], i[2], i[1]);
            par_sdo <= i[0];
            repeat (8) @(posedge clock_in);
            check("par_modes", {10'h000, dcs, fmt, pdn, sdo_oe}, {10'h000, i[3], 1'b0, i[2], i[1], i[0], 1'b0});
        end
        $display("test parallel done");
        end_sim();
    end
endmodule
